//--- bel_align.sv
// Purpose: External bus byte lane steering and access splitting
// Assumes: One outstanding access; ext_ack ends each piece
// Notes: Pieces of a split access are issued back to back
`default_nettype none

module bel_align (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic endian_select_pin,
   input wire bel_pkg::bel_width_t dev_width,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire bel_pkg::bel_size_t req_size,
   input wire logic [31:0] req_addr,
   input wire logic [31:0] req_wdata,
   output logic rsp_valid,
   output logic [31:0] rsp_rdata,
   output logic little_endian,
   output logic ext_valid,
   output logic ext_write,
   output logic [31:0] ext_addr,
   output logic [31:0] ext_wdata,
   input wire logic [31:0] ext_rdata,
   input wire logic ext_ack,
   output logic lane0_write_strobe,
   output logic lane1_write_strobe,
   output logic lane2_write_strobe,
   output logic lane3_write_strobe
);
   import bel_pkg::*;

   typedef enum logic {ST_IDLE, ST_BUS} bel_state_t;

   bel_state_t state_r;
   logic little_r;
   bel_width_t width_r;
   bel_size_t size_r;
   logic [31:0] addr_r;
   logic [31:0] wdata_r;
   logic write_r;
   logic [1:0] idx_r;
   logic last_r;
   logic [3:0] strobe_r;
   logic [7:0] lane_sig_r;
   logic [1:0] off_r;
   logic [31:0] ext_wdata_r;
   logic [31:0] rdata_r;
   logic [31:0] rd_merge;
   logic rsp_valid_r;
   logic accept;
   logic step;
   logic finish;

   bel_map_if mi ();

   bel_lane_map u_map (
      .m(mi)
   );

   assign req_ready = (state_r == ST_IDLE);
   assign accept = req_valid && req_ready;
   assign step = (state_r == ST_BUS) && ext_ack && !last_r;
   assign finish = (state_r == ST_BUS) && ext_ack && last_r;

   // Piece description: fresh request, or the next piece of the current one
   always_comb begin
      mi.little = little_r;
      if (state_r == ST_IDLE) begin
         mi.width = dev_width;
         mi.size = req_size;
         mi.base = req_addr[1:0];
         mi.idx = 2'h0;
         mi.wdata = req_wdata;
      end else begin
         mi.width = width_r;
         mi.size = size_r;
         mi.base = addr_r[1:0];
         mi.idx = 2'(idx_r + 2'h1);
         mi.wdata = wdata_r;
      end
   end

   // Read bytes land at their place in the access word
   always_comb begin
      rd_merge = rdata_r;
      for (int l = 0; l < BEL_LANES; l++) begin
         if (strobe_r[l]) begin
            rd_merge[lane_sig_r[l*2 +: 2]*8 +: 8] = ext_rdata[l*8 +: 8];
         end
      end
   end

   // Byte order caught while reset is held
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         little_r <= endian_select_pin;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state_r <= ST_IDLE;
      end else if (accept) begin
         state_r <= ST_BUS;
      end else if (finish) begin
         state_r <= ST_IDLE;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         width_r <= BEL_W32;
         size_r <= BEL_SZ_BYTE;
         addr_r <= 32'h0000_0000;
         wdata_r <= 32'h0000_0000;
         write_r <= 1'b0;
      end else if (accept) begin
         width_r <= dev_width;
         size_r <= req_size;
         addr_r <= req_addr;
         wdata_r <= req_wdata;
         write_r <= req_write;
      end
   end

   // Pieces follow one another with no idle cycle
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         idx_r <= 2'h0;
         last_r <= 1'b0;
         strobe_r <= BEL_STROBE_NONE;
         lane_sig_r <= 8'h00;
         off_r <= 2'h0;
         ext_wdata_r <= 32'h0000_0000;
      end else if (accept || step) begin
         idx_r <= mi.idx;
         last_r <= mi.last;
         strobe_r <= mi.strobe;
         lane_sig_r <= mi.lane_sig;
         off_r <= mi.off;
         ext_wdata_r <= mi.lane_data;
      end else if (finish) begin
         strobe_r <= BEL_STROBE_NONE;
         last_r <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rdata_r <= 32'h0000_0000;
         rsp_valid_r <= 1'b0;
         rsp_rdata <= 32'h0000_0000;
      end else begin
         rsp_valid_r <= finish;
         if (accept) begin
            rdata_r <= 32'h0000_0000;
         end else if (step) begin
            rdata_r <= rd_merge;
         end
         if (finish) begin
            rsp_rdata <= write_r ? 32'h0000_0000 : rd_merge;
         end
      end
   end

   assign little_endian = little_r;
   assign rsp_valid = rsp_valid_r;
   assign ext_valid = (state_r == ST_BUS);
   assign ext_write = write_r;
   assign ext_addr = {addr_r[31:2], off_r};
   assign ext_wdata = ext_wdata_r;
   assign lane0_write_strobe = strobe_r[0];
   assign lane1_write_strobe = strobe_r[1];
   assign lane2_write_strobe = strobe_r[2];
   assign lane3_write_strobe = strobe_r[3];

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   sequence s_piece_done;
      ext_valid && ext_ack && !last_r;
   endsequence

   sequence s_next_piece;
      ext_valid && (strobe_r != BEL_STROBE_NONE);
   endsequence

   a_idle_strobes: assert property (
      !ext_valid |-> strobe_r == BEL_STROBE_NONE)
      else $error("strobe high with no access");
   a_endian_hold: assert property (
      !$past(srst) |-> $stable(little_endian))
      else $error("byte order changed after reset");
   a_back_to_back: assert property (
      s_piece_done |=> s_next_piece)
      else $error("gap between pieces");
   a_narrow_lane0: assert property (
      ext_valid && width_r == BEL_W8 |-> strobe_r == BEL_STROBE_LANE0)
      else $error("8-bit device off lane zero");
   a_byte8_order: assert property (
      (s_piece_done and width_r == BEL_W8)
      |=> off_r == 2'($past(off_r) + 2'h1))
      else $error("8-bit pieces out of order");
   a_be8_word_first: assert property (
      ext_valid && width_r == BEL_W8 && size_r == BEL_SZ_WORD && !little_r
      && idx_r == 2'h0 |-> ext_wdata[7:0] == wdata_r[15:8])
      else $error("8-bit word not high byte first");
   a_le8_long_last: assert property (
      ext_valid && width_r == BEL_W8 && size_r == BEL_SZ_LONG && little_r
      && idx_r == 2'h3 |-> ext_wdata[7:0] == wdata_r[31:24] && off_r == 2'h3)
      else $error("8-bit long last piece wrong");
   a_le32_byte_lane: assert property (
      ext_valid && width_r == BEL_W32 && size_r == BEL_SZ_BYTE && little_r
      |-> strobe_r == 4'(BEL_STROBE_LANE0 << addr_r[1:0]))
      else $error("32-bit byte on wrong lane");
   a_w32_long_all: assert property (
      ext_valid && width_r == BEL_W32 && size_r == BEL_SZ_LONG
      |-> strobe_r == BEL_STROBE_ALL && last_r)
      else $error("32-bit long not single full access");
   a_w16_two_lanes: assert property (
      ext_valid && width_r == BEL_W16 && size_r != BEL_SZ_BYTE
      |-> strobe_r == BEL_STROBE_LOW2)
      else $error("16-bit word or long not on lanes 0-1");
   a_be16_byte: assert property (
      ext_valid && width_r == BEL_W16 && size_r == BEL_SZ_BYTE && !little_r
      |-> strobe_r == (addr_r[0] ? 4'h1 : 4'h2))
      else $error("16-bit big-endian byte lane wrong");
   a_le16_long_hi: assert property (
      ext_valid && width_r == BEL_W16 && size_r == BEL_SZ_LONG && little_r
      && idx_r == 2'h1 |-> ext_wdata[15:0] == wdata_r[31:16])
      else $error("16-bit long second half wrong");
endmodule : bel_align

`default_nettype wire

//--- bel_lane_map.sv
// Purpose: Places one piece of an access on the byte lanes
// Assumes: Accesses are naturally aligned
// Notes: lane_sig holds, per lane, which byte of the access it carries
`default_nettype none

module bel_lane_map (
   bel_map_if.map m
);
   import bel_pkg::*;

   function automatic logic [2:0] nbytes(input logic [1:0] code);
      logic [2:0] r;
      r = 3'h1;
      if (code == 2'h1) begin
         r = 3'h2;
      end else if (code == 2'h2) begin
         r = 3'h4;
      end
      return r;
   endfunction : nbytes

   logic [2:0] wb;
   logic [2:0] sb;
   logic [2:0] per;
   logic [1:0] a;
   logic [1:0] b;
   logic [1:0] pos;
   logic [1:0] lane;
   logic [1:0] d;
   logic [1:0] sig;
   logic [2:0] pieces;

   always_comb begin
      wb = nbytes(m.width);
      sb = nbytes(m.size);
      per = (sb > wb) ? wb : sb;
      pieces = (sb > wb) ? ((wb == 3'h1) ? sb : 3'(sb >> 1)) : 3'h1;
      a = 2'(m.base + 2'(m.idx * wb[1:0]));
      if (wb == 3'h4) begin
         a = m.base;
      end
      m.off = a;
      m.strobe = BEL_STROBE_NONE;
      m.lane_data = 32'h0000_0000;
      m.lane_sig = 8'h00;
      m.last = ({1'b0, m.idx} == 3'(pieces - 3'h1));
      b = 2'h0;
      pos = 2'h0;
      lane = 2'h0;
      d = 2'h0;
      sig = 2'h0;
      // Walk the bytes of this piece; unused lanes keep strobe low
      for (int k = 0; k < BEL_LANES; k++) begin
         if (3'(k) < per) begin
            b = 2'(a + 2'(k));
            pos = b & 2'(wb - 3'h1);
            lane = m.little ? pos : 2'(wb - 3'h1 - {1'b0, pos});
            d = 2'(b - m.base);
            sig = m.little ? d : 2'(sb - 3'h1 - {1'b0, d});
            m.strobe[lane] = 1'b1;
            m.lane_data[lane*8 +: 8] = m.wdata[sig*8 +: 8];
            m.lane_sig[lane*2 +: 2] = sig;
         end
      end
   end
endmodule : bel_lane_map

`default_nettype wire

//--- bel_map_if.sv
// Purpose: Carrier between the sequencer and the lane mapper
// Assumes: Combinational mapping, one piece at a time
// Notes: seq drives the piece description, map returns the placement
`default_nettype none

interface bel_map_if;
   import bel_pkg::*;
   logic little;
   bel_width_t width;
   bel_size_t size;
   logic [1:0] base;
   logic [1:0] idx;
   logic [31:0] wdata;
   logic [1:0] off;
   logic [31:0] lane_data;
   logic [3:0] strobe;
   logic [7:0] lane_sig;
   logic last;
   modport seq (output little, width, size, base, idx, wdata,
                input off, lane_data, strobe, lane_sig, last);
   modport map (input little, width, size, base, idx, wdata,
                output off, lane_data, strobe, lane_sig, last);
endinterface : bel_map_if

`default_nettype wire

//--- bel_mem_model.sv
// Purpose: Behavioural external device on the byte lanes
// Assumes: Lane data is a fixed pattern of address and lane
// Notes: stall holds off the acknowledge
`default_nettype none

module bel_mem_model (
   input wire logic sys_clk,
   input wire logic ext_valid,
   input wire logic [31:0] ext_addr,
   input wire logic [3:0] strobe,
   input wire logic stall,
   output logic [31:0] ext_rdata,
   output logic ext_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt_r = 8'h00;
   logic [7:0] lane_byte;
   always_ff @(posedge sys_clk) begin
      cnt_r <= cnt_r + 8'h01;
   end
   always_comb begin
      ext_ack = ext_valid & ~stall;
      for (int l = 0; l < 4; l++) begin
         lane_byte = {ext_addr[5:0], 2'(l)} ^ 8'h3C;
         // Idle lanes carry a pattern that changes every cycle
         ext_rdata[8*l +: 8] = (ext_valid && strobe[l]) ? lane_byte
                               : ~lane_byte ^ cnt_r;
      end
   end
endmodule : bel_mem_model

`default_nettype wire

//--- bel_pkg.sv
// Purpose: Constants and types for the external byte lane alignment block
// Assumes: 32-bit external data bus with four byte lanes
// Notes: Behaviour list below
// Behaviour
// - Byte order is latched from the endian pin in reset; high is little.
// - 16-bit BE: even bytes on lane 1, odd on lane 0, long 31-16 then 15-0.
// - 8-bit BE: every byte access uses lane 0 with only strobe 0.
// - 8-bit BE: word high byte first, long at offsets 0-3 from bits 31-24.
// - 32-bit LE: a byte at offset n goes on lane n with strobe n.
// - 32-bit LE: word at 0 on lanes 0-1, at 2 on lanes 2-3, long all lanes.
// - 16-bit LE: even bytes on lane 0, odd on lane 1, word 15-8 on lane 1.
// - 16-bit LE: long on lanes 0-1 as offset 0 bits 15-0, then 31-16.
// - 8-bit LE: lane 0 only, word low byte first, long bits 7-0 first.
`default_nettype none

package bel_pkg;
   typedef enum logic [1:0] {BEL_W8, BEL_W16, BEL_W32} bel_width_t;
   typedef enum logic [1:0] {BEL_SZ_BYTE, BEL_SZ_WORD, BEL_SZ_LONG} bel_size_t;
   localparam logic BEL_ENDIAN_BIG = 1'b0;
   localparam int BEL_LANES = 4;
   localparam logic [3:0] BEL_STROBE_NONE = 4'h0;
   localparam logic [3:0] BEL_STROBE_LANE0 = 4'h1;
   localparam logic [3:0] BEL_STROBE_LOW2 = 4'h3;
   localparam logic [3:0] BEL_STROBE_ALL = 4'hF;
endpackage : bel_pkg

`default_nettype wire

//--- external_byte_lane_alignment_tb.sv
// Purpose: Self-checking bench for bel_align
// Assumes: Partner acks at once unless stalled at random
// Notes: Every width, size, aligned offset and direction in both byte orders
`default_nettype none

module external_byte_lane_alignment_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import bel_pkg::*;
   typedef struct {logic [31:0] a; logic [3:0] st; logic [31:0] d;
                   logic wr;} bel_piece_t;
   bel_piece_t pq[$];
   logic [31:0] rq[$];
   int seed = 36;
   int fail_count = 0;
   int check_count = 0;
   logic sys_clk = 1'b0, srst = 1'b1, pin = 1'b0, req_valid = 1'b0;
   logic req_write = 1'b0, stall = 1'b0, req_ready, rsp_valid, le;
   bel_width_t dev_width = BEL_W8;
   bel_size_t req_size = BEL_SZ_BYTE;
   logic [31:0] req_addr = 32'h0, req_wdata = 32'h0, rsp_rdata;
   logic [31:0] ext_addr, ext_wdata, ext_rdata;
   logic ext_valid, ext_write, ext_ack;
   wire logic [3:0] strb;
   logic exp_le = 1'b0;
   always #4 sys_clk = ~sys_clk;
   bel_align bel_align_inst (.sys_clk(sys_clk), .srst(srst),
      .endian_select_pin(pin), .dev_width(dev_width),
      .req_valid(req_valid), .req_ready(req_ready),
      .req_write(req_write), .req_size(req_size), .req_addr(req_addr),
      .req_wdata(req_wdata), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .little_endian(le), .ext_valid(ext_valid),
      .ext_write(ext_write), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
      .ext_rdata(ext_rdata), .ext_ack(ext_ack),
      .lane0_write_strobe(strb[0]), .lane1_write_strobe(strb[1]),
      .lane2_write_strobe(strb[2]), .lane3_write_strobe(strb[3]));
   bel_mem_model bel_mem_model_inst (.sys_clk(sys_clk),
      .ext_valid(ext_valid), .ext_addr(ext_addr), .strobe(strb),
      .stall(stall), .ext_rdata(ext_rdata), .ext_ack(ext_ack));

   task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_sim

   // Notes the expected pieces and answer, then presents the request
   task automatic send(logic wr, bel_width_t wd, bel_size_t sz,
                       logic [1:0] base);
      int w, s, n, off, ln, bi;
      logic [31:0] a, d, rd;
      bel_piece_t p;
      w = (wd == BEL_W8) ? 1 : (wd == BEL_W16) ? 2 : 4;
      s = (sz == BEL_SZ_BYTE) ? 1 : (sz == BEL_SZ_WORD) ? 2 : 4;
      n = (s > w) ? s / w : 1;
      a = $random(seed);
      a[1:0] = base;
      d = $random(seed);
      if (s < 4)
         d = d & ((32'h1 << (8 * s)) - 32'h1);
      rd = 32'h0;
      for (int i = 0; i < n; i++) begin
         off = base + i * w;
         p.a = {a[31:2], 2'(off)};
         p.st = 4'h0;
         p.d = 32'h0;
         p.wr = wr;
         for (int b = off; b < off + ((s < w) ? s : w); b++) begin
            ln = exp_le ? b % w : w - 1 - b % w;
            bi = exp_le ? b - base : s - 1 - (b - base);
            p.st[ln] = 1'b1;
            p.d[8*ln +: 8] = d[8*bi +: 8];
            rd[8*bi +: 8] = {a[5:2], 2'(off), 2'(ln)} ^ 8'h3C;
         end
         pq.push_back(p);
      end
      rq.push_back(wr ? 32'h0 : rd);
      req_valid = 1'b1;
      req_write = wr;
      dev_width = wd;
      req_size = sz;
      req_addr = a;
      req_wdata = d;
      while (req_ready !== 1'b1)
         @(negedge sys_clk);
      @(negedge sys_clk);
   endtask : send

   always @(negedge sys_clk) begin
      stall <= ($random(seed) % 4 == 0);
   end

   always @(posedge sys_clk) begin
      bel_piece_t p;
      if (!srst && !ext_valid)
         check("idle strobes", 32'(strb), 32'h0);
      if (!srst)
         check("req_ready", 32'(req_ready), 32'(!ext_valid));
      if (!srst && ext_valid && ext_ack) begin
         if (pq.size() == 0) begin
            check("unexpected piece", 32'h1, 32'h0);
         end else begin
            p = pq.pop_front();
            check("ext_addr", ext_addr, p.a);
            check("strobes", 32'(strb), 32'(p.st));
            check("ext_write", 32'(ext_write), 32'(p.wr));
            if (p.wr)
               check("ext_wdata", ext_wdata, p.d);
         end
      end
      if (!srst && rsp_valid) begin
         if (rq.size() == 0)
            check("unexpected answer", 32'h1, 32'h0);
         else
            check("rsp_rdata", rsp_rdata, rq.pop_front());
      end
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      fail_count++;
      end_sim();
   end

   initial begin
      for (int e = 0; e < 2; e++) begin
         pin = e[0];
         exp_le = e[0];
         srst = 1'b1;
         repeat (3) @(negedge sys_clk);
         srst = 1'b0;
         pin = ~e[0];
         @(negedge sys_clk);
         check("little_endian", 32'(le), 32'(e));
         for (int wd = 0; wd < 3; wd++)
            for (int sz = 0; sz < 3; sz++)
               for (int b = 0; b < 4; b += (1 << sz))
                  for (int wr = 0; wr < 2; wr++)
                     send(wr[0], bel_width_t'(wd), bel_size_t'(sz), 2'(b));
         req_valid = 1'b0;
         for (int k = 0; k < 200 && (rq.size() > 0); k++)
            @(negedge sys_clk);
         check("drained", 32'(rq.size() + pq.size()), 32'h0);
         check("little_endian held", 32'(le), 32'(e));
      end
      end_sim();
   end
endmodule : external_byte_lane_alignment_tb

`default_nettype wire
